// file: common/fast_pulse_counter_defines.vh
// Register offsets, field positions, reset values and timing figures of the pulse counter.
`ifndef FAST_PULSE_COUNTER_DEFINES_VH
`define FAST_PULSE_COUNTER_DEFINES_VH

// Register byte offsets.
`define FPC_ADDR_W 5
`define FPC_OFS_CONTROL 5'h00
`define FPC_OFS_PRESET 5'h04
`define FPC_OFS_COUNT 5'h08
`define FPC_OFS_PINS 5'h0C
`define FPC_OFS_CYCLE_END 5'h10
`define FPC_OFS_IRQ_STATUS 5'h14
`define FPC_OFS_IRQ_ENABLE 5'h18
`define FPC_OFS_IRQ_CLEAR 5'h1C

// Control register fields.
`define FPC_CTL_SOFT_ENABLE 0
`define FPC_CTL_GATE_SELECT 1
`define FPC_CTL_LOAD_REQUEST 2
`define FPC_CTL_OUT_DIRECT 3
`define FPC_CTL_W 4
`define FPC_CTL_RESET 4'h0

// Pin and flag register fields.
`define FPC_PIN_ZERO_FLAG 0
`define FPC_PIN_COUNT_MIRROR 1
`define FPC_PIN_GATE_MIRROR 2

// Interrupt status fields.
`define FPC_IRQ_ZERO_CROSS 0
`define FPC_IRQ_WRAP 1
`define FPC_IRQ_LOADED 2
`define FPC_IRQ_W 3
`define FPC_IRQ_RESET 3'h0

// Counter layout.
`define FPC_COUNT_W 16
`define FPC_COUNT_RESET 16'h0000
`define FPC_COUNT_MINUS_ONE 16'hFFFF
`define FPC_COUNT_MAX_POS 16'h7FFF

// Timing figures.
`define FPC_CLOCK_KHZ 200000
`define FPC_PULSE_RATE_MAX_KHZ 50
`define FPC_GATE_DELAY_MAX_US 1500
`define FPC_MIRROR_DELAY_MS 8
`define FPC_MIRROR_CYCLES (`FPC_MIRROR_DELAY_MS * `FPC_CLOCK_KHZ)

`endif

// file: verilog/level_delay.v
// Delays a synchronised level so that the output follows it a fixed time later.
`default_nettype none

module level_delay #(
  parameter integer DELAY_CYCLES = 1600000,
  parameter integer COUNT_W = 21
) (
  // Clock and reset.
  input wire clock,
  input wire rst,
  // Level in and delayed level out.
  input wire level_in,
  output reg level_out_q
);

  reg [COUNT_W-1:0] hold_q;
  reg [COUNT_W-1:0] hold_d;
  reg level_out_d;

  localparam integer LAST_FULL = DELAY_CYCLES - 1;
  localparam [COUNT_W-1:0] LAST = LAST_FULL[COUNT_W-1:0];

  // The output takes a new level only after the input has held it for the whole delay.
  always @*
  begin
    hold_d = {COUNT_W{1'b0}};
    level_out_d = level_out_q;
    if (level_in != level_out_q)
    begin
      if (hold_q == LAST)
      begin
        level_out_d = level_in;
      end
      else
      begin
        hold_d = hold_q + {{(COUNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      hold_q <= {COUNT_W{1'b0}};
      level_out_q <= 1'b0;
    end
    else
    begin
      hold_q <= hold_d;
      level_out_q <= level_out_d;
    end
  end

endmodule

`default_nettype wire

// file: verilog/fast_pulse_counter.v
// Fast 16-bit signed pulse counter with gating, preset, zero-crossing flag and pin mirrors.
//
// Functional notes
// R1: Each low-to-high edge of the count pulse pin adds one to the counter, up to 50 kHz.
// R2: The counter is signed 16 bits and steps from +32767 to -32768 on overflow.
// R3: With gate select at 0 the software enable bit alone enables counting.
// R4: With gate select at 1 the external gate pin enables counting and the software bit is ignored.
// R5: A gate level change may take between zero and 1.5 ms to act on counting.
// R6: A load request copies the preset word into the counter.
// R7: A request held over several program cycles reloads at each cycle end and counts in between.
// R8: The program reads the live counter value through the count word.
// R9: The zero-crossing flag rises when the counter steps from -1 to 0, whatever the gate select.
// R10: The zero-crossing output pin follows the flag only while gate select is 1, within 1.5 ms.
// R11: While gate select is 1 the program cannot drive the zero-crossing output pin directly.
// R12: Loading the counter from the preset clears the zero-crossing flag.
// R13: Both input pin levels are shown to the program as mirrors delayed by 8 ms.
// R14: Counting runs in hardware without waiting on the program.
// R15: Both input pins are synchronised and edges are found on the synchronised level.
// R16: Reset clears counter, flag and output pin and selects the software enable.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`include "fast_pulse_counter_defines.vh"
`default_nettype none

module fast_pulse_counter #(
  parameter integer MIRROR_CYCLES = `FPC_MIRROR_CYCLES,
  parameter integer MIRROR_COUNT_W = 21
) (
  // Clock and reset.
  input wire clock,
  input wire rst,
  // Register port.
  input wire [`FPC_ADDR_W-1:0] addr,
  input wire [31:0] wdata,
  input wire write,
  input wire read,
  output reg [31:0] rdata_q,
  // External pins.
  input wire count_pulse_input,
  input wire external_gate_input,
  output reg zero_cross_output,
  // Interrupt.
  output wire irq
);

  // Input synchronisers: two flops per pin, then an edge history flop on the pulse pin only.
  reg [1:0] pulse_sync_q;
  reg [1:0] gate_sync_q;
  reg pulse_prev_q;

  // Control and data registers.
  reg [`FPC_CTL_W-1:0] control_q;
  reg [`FPC_COUNT_W-1:0] preset_value_word;
  reg [`FPC_COUNT_W-1:0] count_q;
  reg [`FPC_COUNT_W-1:0] count_d;
  reg zero_cross_flag;
  reg zero_cross_flag_d;
  reg zero_cross_output_d;
  reg [`FPC_IRQ_W-1:0] irq_status_q;
  reg [`FPC_IRQ_W-1:0] irq_enable_q;
  reg [`FPC_IRQ_W-1:0] irq_event;

  // Decoded register accesses.
  wire wr_control;
  wire wr_preset;
  wire wr_cycle_end;
  wire wr_irq_enable;
  wire wr_irq_clear;

  // Derived control bits.
  wire soft_count_enable;
  wire gate_source_select;
  wire preset_load_request;
  wire direct_output_value;
  wire pulse_level;
  wire gate_level;
  wire pulse_rise;
  wire count_enable;
  wire do_load;
  wire do_count;
  wire crossing;
  wire wrapping;

  // Delayed pin mirrors.
  wire [1:0] mirror_in;
  wire [1:0] mirror_out;
  wire fast_count_pin_mirror;
  wire fast_gate_pin_mirror;

  wire [`FPC_COUNT_W-1:0] count_value_word;

  assign soft_count_enable = control_q[`FPC_CTL_SOFT_ENABLE];
  assign gate_source_select = control_q[`FPC_CTL_GATE_SELECT];
  assign preset_load_request = control_q[`FPC_CTL_LOAD_REQUEST];
  assign direct_output_value = control_q[`FPC_CTL_OUT_DIRECT];

  assign wr_control = write && (addr == `FPC_OFS_CONTROL);
  assign wr_preset = write && (addr == `FPC_OFS_PRESET);
  assign wr_cycle_end = write && (addr == `FPC_OFS_CYCLE_END);
  assign wr_irq_enable = write && (addr == `FPC_OFS_IRQ_ENABLE);
  assign wr_irq_clear = write && (addr == `FPC_OFS_IRQ_CLEAR);

  // Both pins cross into the clock domain through two flops.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pulse_sync_q <= 2'h0;
      gate_sync_q <= 2'h0;
      pulse_prev_q <= 1'b0;
    end
    else
    begin
      pulse_sync_q <= {pulse_sync_q[0], count_pulse_input}; // see R15
      gate_sync_q <= {gate_sync_q[0], external_gate_input}; // see R15
      pulse_prev_q <= pulse_sync_q[1];
    end
  end

  assign pulse_level = pulse_sync_q[1];
  assign gate_level = gate_sync_q[1];

  // A rising edge is seen once, on the synchronised level.
  assign pulse_rise = pulse_level && !pulse_prev_q; // see R15

  // Gate source selection; the pin path adds only the synchroniser delay, far below 1.5 ms.
  assign count_enable = gate_source_select ? gate_level : soft_count_enable; // see R3 see R4 see R5

  // The program marks the end of each of its cycles by writing the cycle-end register.
  assign do_load = wr_cycle_end && preset_load_request; // see R6 see R7

  // Counting needs no program action at all.
  assign do_count = pulse_rise && count_enable && !do_load; // see R1 see R14

  assign crossing = do_count && (count_q == `FPC_COUNT_MINUS_ONE);
  assign wrapping = do_count && (count_q == `FPC_COUNT_MAX_POS);

  // Next counter value: a load takes priority over a coinciding edge.
  always @*
  begin
    count_d = count_q;
    if (do_load)
    begin
      count_d = preset_value_word; // see R6 see R7
    end
    else if (do_count)
    begin
      count_d = count_q + 16'h0001; // see R1 see R2
    end
  end

  // The flag is sticky until the next load, and a load cannot coincide with a crossing.
  always @*
  begin
    zero_cross_flag_d = zero_cross_flag;
    if (do_load)
    begin
      zero_cross_flag_d = 1'b0; // see R12
    end
    else if (crossing)
    begin
      zero_cross_flag_d = 1'b1; // see R9
    end
  end

  // The pin shows the flag under gate select and the program's bit otherwise.
  always @*
  begin
    if (gate_source_select)
    begin
      zero_cross_output_d = zero_cross_flag_d; // see R10 see R11
    end
    else
    begin
      zero_cross_output_d = direct_output_value;
    end
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      count_q <= `FPC_COUNT_RESET; // see R16
      zero_cross_flag <= 1'b0; // see R16
      zero_cross_output <= 1'b0; // see R16
    end
    else
    begin
      count_q <= count_d;
      zero_cross_flag <= zero_cross_flag_d;
      zero_cross_output <= zero_cross_output_d;
    end
  end

  assign count_value_word = count_q; // see R8

  // Control and preset registers.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      control_q <= `FPC_CTL_RESET; // see R16
      preset_value_word <= `FPC_COUNT_RESET;
      irq_enable_q <= `FPC_IRQ_RESET;
    end
    else
    begin
      if (wr_control)
      begin
        control_q <= wdata[`FPC_CTL_W-1:0];
      end
      if (wr_preset)
      begin
        preset_value_word <= wdata[`FPC_COUNT_W-1:0];
      end
      if (wr_irq_enable)
      begin
        irq_enable_q <= wdata[`FPC_IRQ_W-1:0];
      end
    end
  end

  // Interrupt events.
  always @*
  begin
    irq_event = {`FPC_IRQ_W{1'b0}};
    irq_event[`FPC_IRQ_ZERO_CROSS] = crossing;
    irq_event[`FPC_IRQ_WRAP] = wrapping;
    irq_event[`FPC_IRQ_LOADED] = do_load;
  end

  // Writing a one clears a status bit; an event in the same cycle keeps it set.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      irq_status_q <= `FPC_IRQ_RESET;
    end
    else if (wr_irq_clear)
    begin
      irq_status_q <= (irq_status_q & ~wdata[`FPC_IRQ_W-1:0]) | irq_event;
    end
    else
    begin
      irq_status_q <= irq_status_q | irq_event;
    end
  end

  assign irq = |(irq_status_q & irq_enable_q);

  // Slow mirrors of both synchronised pin levels.
  assign mirror_in = {gate_level, pulse_level};

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : mirror
      level_delay #(
        .DELAY_CYCLES(MIRROR_CYCLES),
        .COUNT_W(MIRROR_COUNT_W)
      ) delay_inst (
        .clock(clock),
        .rst(rst),
        .level_in(mirror_in[i]),
        .level_out_q(mirror_out[i])
      ); // see R13
    end
  endgenerate

  assign fast_count_pin_mirror = mirror_out[0];
  assign fast_gate_pin_mirror = mirror_out[1];

  // Read data stand only in the cycle after the read strobe.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (!read)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (addr == `FPC_OFS_CONTROL)
    begin
      rdata_q <= {{(32-`FPC_CTL_W){1'b0}}, control_q};
    end
    else if (addr == `FPC_OFS_PRESET)
    begin
      rdata_q <= {16'h0000, preset_value_word};
    end
    else if (addr == `FPC_OFS_COUNT)
    begin
      rdata_q <= {16'h0000, count_value_word}; // see R8
    end
    else if (addr == `FPC_OFS_PINS)
    begin
      rdata_q <= {29'h0000000, fast_gate_pin_mirror, fast_count_pin_mirror,
        zero_cross_flag}; // see R9 see R13
    end
    else if (addr == `FPC_OFS_IRQ_STATUS)
    begin
      rdata_q <= {{(32-`FPC_IRQ_W){1'b0}}, irq_status_q};
    end
    else if (addr == `FPC_OFS_IRQ_ENABLE)
    begin
      rdata_q <= {{(32-`FPC_IRQ_W){1'b0}}, irq_enable_q};
    end
    else
    begin
      rdata_q <= 32'h00000000;
    end
  end

endmodule

`default_nettype wire

// file: verification/fast_pulse_counter_monitor.sv
// Port-level checker for the fast pulse counter.
`include "fast_pulse_counter_defines.vh"
`default_nettype none
module fast_pulse_counter_monitor (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Register port.
  input wire logic [`FPC_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic write,
  input wire logic read,
  input wire logic [31:0] rdata_q,
  // Pins and interrupt.
  input wire logic count_pulse_input,
  input wire logic external_gate_input,
  input wire logic zero_cross_output,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ctl_q;
  logic [15:0] preset_q;
  wire logic en;
  // Shadow of the control and preset registers, taken from the bus.
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctl_q <= 4'h0;
      preset_q <= 16'h0000;
    end
    else if (write && addr == `FPC_OFS_CONTROL)
      ctl_q <= wdata[3:0];
    else if (write && addr == `FPC_OFS_PRESET)
      preset_q <= wdata[15:0];
  end
  assign en = ctl_q[1] ? external_gate_input : ctl_q[0];
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence load_then_read;
    write && addr == `FPC_OFS_CYCLE_END && ctl_q[2] && !en ##2 read && addr == `FPC_OFS_COUNT;
  endsequence
  sequence sel_held;
    ctl_q[1] && $past(ctl_q[1]) && $past(ctl_q[1], 2);
  endsequence
  read_idle_a: assert property (!read |=> rdata_q == 32'h0)
    else $error("read data not zero");
  count_upper_a: assert property (read && addr == `FPC_OFS_COUNT |=> rdata_q[31:16] == 16'h0)
    else $error("count upper bits set");
  reset_out_a: assert property ($fell(rst) |-> !zero_cross_output && !irq && rdata_q == 32'h0)
    else $error("outputs not cleared by reset");
  direct_out_a: assert property (!ctl_q[1] && $stable(ctl_q) |-> zero_cross_output == ctl_q[3])
    else $error("direct output mismatch");
  zero_rise_a: assert property (sel_held ##0 $rose(zero_cross_output) |->
    $past(count_pulse_input, 2) || $past(count_pulse_input, 3) || $past(count_pulse_input, 4))
    else $error("output rose without a pulse");
  zero_fall_a: assert property (sel_held ##0 $fell(zero_cross_output) |->
    $past(write) && $past(addr) == `FPC_OFS_CYCLE_END)
    else $error("output fell without a load");
  load_value_a: assert property (load_then_read |=> rdata_q[15:0] == preset_q)
    else $error("count not loaded from preset");
  irq_mask_a: assert property (write && addr == `FPC_OFS_IRQ_ENABLE && wdata[2:0] == 3'h0 |=> !irq)
    else $error("irq high while masked");
endmodule
bind fast_pulse_counter fast_pulse_counter_monitor fast_pulse_counter_monitor_inst (.clock(clock),
  .rst(rst), .addr(addr), .wdata(wdata), .write(write), .read(read), .rdata_q(rdata_q),
  .count_pulse_input(count_pulse_input), .external_gate_input(external_gate_input),
  .zero_cross_output(zero_cross_output), .irq(irq));
`default_nettype wire

// file: verification/pulse_source.sv
// External pulse source and gate driver for the counter's input pins.
`default_nettype none
module pulse_source (
  // Clock.
  input wire logic clock,
  // Pins.
  output var logic count_pulse_input,
  output var logic external_gate_input
);
  timeunit 1ns;
  timeprecision 1ps;
  int requested = 0;
  int issued = 0;
  int half_len = 2;
  int phase_cnt = 0;
  logic gate_want = 1'b0;
  initial
  begin
    count_pulse_input = 1'b0;
    external_gate_input = 1'b0;
  end
  // The pins change only at a clock edge; each pulse level lasts half_len clocks.
  always @(posedge clock)
  begin
    external_gate_input <= gate_want;
    if (phase_cnt > 1)
      phase_cnt <= phase_cnt - 1;
    else if (count_pulse_input)
    begin
      count_pulse_input <= 1'b0;
      phase_cnt <= half_len;
    end
    else if (issued < requested)
    begin
      count_pulse_input <= 1'b1;
      issued <= issued + 1;
      phase_cnt <= half_len;
    end
  end
  // Each half period spans at least two clocks so the synchroniser sees it.
  task automatic pulses(input int n, input int half);
    @(posedge clock);
    half_len <= half;
    requested <= requested + n;
    repeat (2 * n * half + 4) @(posedge clock);
  endtask
  task automatic set_gate(input logic v);
    @(posedge clock);
    gate_want <= v;
    repeat (4) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the fast pulse counter.
`include "fast_pulse_counter_defines.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] CTL = `FPC_OFS_CONTROL, PRE = `FPC_OFS_PRESET, CNT = `FPC_OFS_COUNT;
  localparam logic [4:0] PIN = `FPC_OFS_PINS, CYC = `FPC_OFS_CYCLE_END;
  localparam logic [4:0] STS = `FPC_OFS_IRQ_STATUS, ENA = `FPC_OFS_IRQ_ENABLE;
  localparam logic [4:0] CLR = `FPC_OFS_IRQ_CLEAR;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clock;
  logic rst;
  logic [4:0] addr;
  logic [31:0] wdata;
  logic write;
  logic read;
  logic [31:0] seen;
  wire [31:0] rdata_q;
  wire count_pulse_input;
  wire external_gate_input;
  wire zero_cross_output;
  wire irq;
  int n_fail;
  int checked;
  fast_pulse_counter #(.MIRROR_CYCLES(16), .MIRROR_COUNT_W(5)) fast_pulse_counter_inst (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .write(write), .read(read),
    .rdata_q(rdata_q), .count_pulse_input(count_pulse_input),
    .external_gate_input(external_gate_input), .zero_cross_output(zero_cross_output), .irq(irq));
  pulse_source pulse_source_inst (.clock(clock), .count_pulse_input(count_pulse_input),
    .external_gate_input(external_gate_input));
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic complete_run();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    write <= 1'b1;
    @(posedge clock);
    write <= 1'b0;
    #1;
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clock);
    addr <= a;
    read <= 1'b1;
    @(posedge clock);
    read <= 1'b0;
    #1;
    seen = rdata_q;
    chk($sformatf("reg %h", a), seen & m, e);
  endtask
  initial
  begin
    #400000;
    n_fail++;
    complete_run();
  end
  initial
  begin
    rst = 1'b1;
    addr = 5'h00;
    wdata = 32'h0;
    write = 1'b0;
    read = 1'b0;
    n_fail = 0;
    checked = 0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rc(CTL, 32'h0, 32'hF);
    rc(CNT, 32'h0, ALL);
    rc(PIN, 32'h0, 32'h7);
    rc(STS, 32'h0, 32'h7);
    rc(CYC, 32'h0, ALL);
    wr(CTL, 32'h1);
    pulse_source_inst.pulses(5, 3);
    rc(CNT, 32'h5, ALL);
    wr(CTL, 32'h0);
    pulse_source_inst.pulses(3, 6);
    rc(CNT, 32'h5, ALL);
    fork
      pulse_source_inst.pulses(1, 30);
      begin
        repeat (25) @(posedge clock);
        rc(PIN, 32'h2, 32'h2);
      end
    join
    rc(CNT, 32'h5, ALL);
    wr(CTL, 32'h2);
    pulse_source_inst.set_gate(1'b1);
    rc(PIN, 32'h0, 32'h4);
    pulse_source_inst.pulses(4, 3);
    repeat (20) @(posedge clock);
    rc(CNT, 32'h9, ALL);
    rc(PIN, 32'h4, 32'h6);
    pulse_source_inst.set_gate(1'b0);
    wr(CTL, 32'h3);
    pulse_source_inst.pulses(2, 3);
    rc(CNT, 32'h9, ALL);
    wr(PRE, 32'h7FFE);
    wr(CTL, 32'h5);
    wr(CYC, 32'h0);
    rc(CNT, 32'h7FFE, ALL);
    pulse_source_inst.pulses(2, 3);
    rc(CNT, 32'h8000, ALL);
    wr(CYC, 32'h0);
    rc(CNT, 32'h7FFE, ALL);
    rc(STS, 32'h6, 32'h7);
    wr(CLR, 32'h7);
    rc(STS, 32'h0, 32'h7);
    wr(PRE, 32'hFFFE);
    pulse_source_inst.set_gate(1'b1);
    wr(CTL, 32'h6);
    wr(CYC, 32'h0);
    rc(PIN, 32'h0, 32'h1);
    pulse_source_inst.pulses(2, 6);
    rc(CNT, 32'h0, ALL);
    rc(PIN, 32'h1, 32'h1);
    chk("zero_cross_output", zero_cross_output, 32'h1);
    wr(ENA, 32'h1);
    chk("irq", irq, 32'h1);
    rc(STS, 32'h5, 32'h7);
    wr(ENA, 32'h0);
    chk("irq", irq, 32'h0);
    wr(CLR, 32'h7);
    rc(STS, 32'h0, 32'h7);
    wr(ENA, 32'h7);
    chk("irq", irq, 32'h0);
    pulse_source_inst.set_gate(1'b0);
    wr(CTL, 32'hE);
    wr(CYC, 32'h0);
    chk("zero_cross_output", zero_cross_output, 32'h0);
    rc(CNT, 32'hFFFE, ALL);
    wr(CTL, 32'h8);
    rc(PIN, 32'h0, 32'h1);
    chk("zero_cross_output", zero_cross_output, 32'h1);
    chk("irq", irq, 32'h1);
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    #1;
    chk("irq", irq, 32'h0);
    chk("zero_cross_output", zero_cross_output, 32'h0);
    @(posedge clock);
    rst <= 1'b0;
    rc(CTL, 32'h0, 32'hF);
    rc(CNT, 32'h0, ALL);
    rc(PIN, 32'h0, 32'h1);
    complete_run();
  end
endmodule
`default_nettype wire
